// ---- bench/sdm_conv_model.sv ----
// Converter model: forwarded clock with one sample per clock edge
`timescale 1ns/1ps
module sdm_conv_model (
    // Link to the demultiplexer
    output logic       link_clk,
    output logic [9:0] link_data
);
    logic busy = 1'b0;
    initial begin
        link_clk = 1'b0;
        link_data = 10'h000;
    end
    // Released data line keeps changing
    always #4 if (!busy) link_data = ~link_data;
    // Clock runs only within a burst
    task automatic send(input logic [9:0] v, input int n);
        busy = 1'b1;
        #1;
        for (int i = 0; i < n; i++) begin
            link_data = v + 10'(i);
            #16 link_clk = ~link_clk;
            #16;
        end
        busy = 1'b0;
    endtask
endmodule // sdm_conv_model

// ---- bench/sdm_top_monitor.sv ----
// Port checker of the sample demultiplexer
`timescale 1ns/1ps
module sdm_top_monitor (
    // Clock and reset
    input logic        CLK,
    input logic        RST_B,
    // Register bus
    input logic        HSEL,
    input logic [31:0] HADDR,
    input logic [1:0]  HTRANS,
    input logic        HWRITE,
    input logic [31:0] HWDATA,
    input logic        HREADY,
    // Link and ports
    input logic        LINK_CLK,
    input logic        DEMUX_RESET_IN,
    input logic [9:0]  PORT_A,
    input logic [9:0]  PORT_B,
    input logic [9:0]  PORT_C,
    input logic [9:0]  PORT_D,
    input logic        OUT_CLK
);
    logic       wr_q;
    logic [8:0] ctrl_q;
    logic [3:0] act_q;
    // Shadow of control writes and of settings latched by demux reset
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_q   <= 1'b0;
            ctrl_q <= 9'h03f;
            act_q  <= 4'hf;
        end else begin
            wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE && (HADDR[11:2] == 10'h000);
            if (wr_q) ctrl_q <= HWDATA[8:0];
            if (DEMUX_RESET_IN) act_q <= ctrl_q[3:0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    chk_reset_clk_low: assert property (DEMUX_RESET_IN [*5] |-> !OUT_CLK)
        else $error("clock high in demux reset");
    chk_reset_hold: assert property (DEMUX_RESET_IN [*5] |-> $stable(PORT_A) && $stable(PORT_D))
        else $error("port moved in demux reset");
    chk_sleep_frozen: assert property (!act_q[2] && !DEMUX_RESET_IN |-> $stable(PORT_A) && $stable(OUT_CLK))
        else $error("outputs moved in sleep");
    chk_two_port_idle: assert property (!ctrl_q[4] && !DEMUX_RESET_IN |-> $stable(PORT_C))
        else $error("port C moved in two-port mode");
    chk_simul_together: assert property (act_q[3] && ctrl_q[4] && $changed(PORT_D) |-> $changed(PORT_A))
        else $error("ports not loaded together");
    chk_stagger_apart: assert property (!act_q[3] && $changed(PORT_B) |-> $stable(PORT_A))
        else $error("staggered ports loaded together");
    chk_edge_capture: assert property (act_q[0] && act_q[2] && !act_q[3] && !ctrl_q[8] && !DEMUX_RESET_IN
        && $fell(LINK_CLK) |-> ##[2:10] ($changed(PORT_A) || $changed(PORT_B) || $changed(PORT_C)))
        else $error("falling link edge not captured");
    chk_selftest_ramp: assert property (!ctrl_q[5] && act_q[3] && ctrl_q[4] && $changed(PORT_D)
        |-> PORT_D == PORT_A + 10'h003)
        else $error("test pattern not a ramp");
endmodule // sdm_top_monitor

// ---- bench/sdm_top_tb.sv ----
// Testbench of the sample demultiplexer
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module sdm_top_tb;
    logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, dmx_rst = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire  [31:0] hrdata;
    wire         hready, hresp, link_clk, out_clk;
    wire  [9:0]  link_data, pa, pb, pc, pd;
    int          n_fail = 0, checked = 0;
    sdm_top dut (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .LINK_CLK(link_clk), .LINK_DATA(link_data), .DEMUX_RESET_IN(dmx_rst), .PORT_A(pa), .PORT_B(pb),
        .PORT_C(pc), .PORT_D(pd), .OUT_CLK(out_clk));
    sdm_conv_model conv (.link_clk(link_clk), .link_data(link_data));
    initial forever #2 clk = ~clk;
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
        `CHK(hresp, 1'b0)
    endtask
    // New settings followed by a demux reset pulse
    task automatic mode(input logic [31:0] v);
        bus(1'b1, 12'h000, v);
        dmx_rst <= 1'b1;
        repeat (6) @(posedge clk);
        dmx_rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic feed(input logic [9:0] v, input int n);
        conv.send(v, n);
        repeat (8) @(posedge clk);
    endtask
    task automatic t_regs;
        rchk(12'h000, 32'h3f);
        bus(1'b1, 12'h008, 32'h0);
        rchk(12'h008, 32'hf);
        rchk(12'h00c, 32'h0);
        $display("regs done");
    endtask
    task automatic t_four;
        feed(10'h100, 8);
        `CHK(pa, 10'h104)
        `CHK(pb, 10'h105)
        `CHK(pc, 10'h106)
        `CHK(pd, 10'h107)
        `CHK(out_clk, 1'b1)
        $display("four done");
    endtask
    task automatic t_two;
        mode(32'h2f);
        feed(10'h200, 3);
        `CHK(pa, 10'h200)
        `CHK(pb, 10'h201)
        `CHK(pc, 10'h106)
        $display("two done");
    endtask
    task automatic t_stag;
        mode(32'h37);
        feed(10'h300, 1);
        `CHK(pa, 10'h300)
        `CHK(pb, 10'h201)
        `CHK(out_clk, 1'b0)
        feed(10'h301, 1);
        `CHK(pb, 10'h301)
        $display("stagger done");
    endtask
    task automatic t_rate;
        mode(32'h3d);
        feed(10'h040, 4);
        `CHK(out_clk, 1'b1)
        feed(10'h044, 4);
        `CHK(out_clk, 1'b0)
        $display("rate done");
    endtask
    task automatic t_sleep;
        mode(32'h33);
        feed(10'h3a0, 4);
        `CHK(pa, 10'h044)
        $display("sleep done");
    endtask
    task automatic t_self_test_select;
        mode(32'h1f);
        feed(10'h050, 4);
        `CHK(pa, 10'h000)
        `CHK(pd, 10'h003)
        $display("self-test done");
    endtask
    task automatic t_fifo;
        mode(32'h13f);
        feed(10'h000, 17);
        rchk(12'h004, 32'h1014);
        bus(1'b1, 12'h004, 32'h4);
        rchk(12'h004, 32'h1010);
        bus(1'b1, 12'h000, 32'h3f);
        repeat (40) @(posedge clk);
        rchk(12'h004, 32'h8);
        `CHK(pa, 10'h00c)
        `CHK(pd, 10'h00f)
        $display("fifo done");
    endtask
    task automatic t_rise;
        mode(32'h3e);
        feed(10'h080, 8);
        `CHK(pa, 10'h080)
        `CHK(pb, 10'h082)
        `CHK(pc, 10'h084)
        `CHK(pd, 10'h086)
        `CHK(out_clk, 1'b1)
        $display("rise done");
    endtask
    task automatic print_verdict;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs;
        t_four;
        t_two;
        t_stag;
        t_rate;
        t_sleep;
        t_self_test_select;
        t_fifo;
        t_rise;
        print_verdict;
    end
    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        print_verdict;
    end
endmodule // sdm_top_tb
bind sdm_top sdm_top_monitor mon (.CLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY,
    .LINK_CLK, .DEMUX_RESET_IN, .PORT_A, .PORT_B, .PORT_C, .PORT_D, .OUT_CLK);

// ---- design/sdm_fifo.v ----
// Sample FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sdm_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_b,
    input  wire             flush,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Fill level
    output wire [AW:0]      count
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_q;
    reg  [AW-1:0]    rd_q;
    reg  [AW:0]      cnt_q;
    wire             push;
    wire             pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem[rd_q];
    assign count     = cnt_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // sdm_fifo

// ---- design/sdm_regs.vh ----
// Register offsets, field positions, reset values and sizes of the sample demultiplexer
`ifndef SDM_REGS_VH
`define SDM_REGS_VH

// Register byte offsets
`define SDM_CTRL_OFS        12'h000
`define SDM_STATUS_OFS      12'h004
`define SDM_ACTIVE_OFS      12'h008

// Control and active-setting field positions
`define SDM_EDGE_BIT        0
`define SDM_RATE_BIT        1
`define SDM_AWAKE_BIT       2
`define SDM_SIMUL_BIT       3
`define SDM_RATIO_BIT       4
`define SDM_NORMAL_BIT      5
`define SDM_HOLD_BIT        8

// Status field positions
`define SDM_ST_IDX_LSB      0
`define SDM_ST_IDX_MSB      1
`define SDM_ST_OVF_BIT      2
`define SDM_ST_EMPTY_BIT    3
`define SDM_ST_FULL_BIT     4
`define SDM_ST_CNT_LSB      8
`define SDM_ST_CNT_MSB      12

// Reset values: every select reads as if left floating
`define SDM_CTRL_RST        9'h03f
`define SDM_ACTIVE_RST      4'hf

// Sizes
`define SDM_SAMPLE_W        10
`define SDM_FIFO_DEPTH      16
`define SDM_FIFO_AW         4
`define SDM_NPORTS          4

`endif

// ---- design/sdm_top.v ----
// Sample demultiplexer: link capture, FIFO, port distribution and AHB-Lite registers
//
// Overview of operation
// - The demux reset input is active high and holds the demultiplexing state reset while asserted.
// - The block runs from power-up without a demux reset; changes to power, skew, edge or rate settings need one.
// - After a demux reset the first delivered sample goes to port A.
// - With the edge select at 1, samples are captured on both edges of the forwarded link clock.
// - With the rate select high the output clock runs single rate, with it low it runs half rate.
// - With the power select at 0 the ports freeze and conversion stops; at 1 it converts normally.
// - With the skew select at 0 ports update staggered; at 1 they update together.
// - With the ratio select at 0 samples spread over two ports; at 1 over four.
// - With the self-test select at 0 a test pattern replaces the converter data; at 1 normal conversion.
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sdm_regs.vh"
module sdm_top (
    // Clock and reset
    input  wire        CLK,
    input  wire        RST_B,
    // AHB-Lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire [31:0] HRDATA,
    output wire        HREADYOUT,
    output wire        HRESP,
    // Converter link
    input  wire        LINK_CLK,
    input  wire [9:0]  LINK_DATA,
    input  wire        DEMUX_RESET_IN,
    // Output ports
    output wire [9:0]  PORT_A,
    output wire [9:0]  PORT_B,
    output wire [9:0]  PORT_C,
    output wire [9:0]  PORT_D,
    output wire        OUT_CLK
);
    localparam SW = `SDM_SAMPLE_W;
    localparam NP = `SDM_NPORTS;

    // Pin synchronisers
    reg           lclk_s1_q;
    reg           lclk_s2_q;
    reg           lclk_s3_q;
    reg  [SW-1:0] ldat_s1_q;
    reg  [SW-1:0] ldat_s2_q;
    reg           drst_s1_q;
    reg           drst_s2_q;

    // Registers
    reg  [8:0]    ctrl_q;
    reg  [3:0]    act_q;
    reg           ovf_q;
    reg           ovf_d;

    // Bus slave
    reg           wr_pend_q;
    reg  [11:0]   wr_addr_q;
    reg  [31:0]   hrdata_q;
    reg  [31:0]   rd_val;
    reg           hreadyout_q;
    reg           hresp_q;
    wire          addr_ok;
    wire          rd_take;
    wire          wr_take;
    wire          wr_ctrl;
    wire          wr_status;
    wire          ovf_clr;
    wire          ovf_set;

    // Datapath
    reg  [SW-1:0] pattern_q;
    reg  [1:0]    idx_q;
    reg           oclk_q;
    reg  [SW-1:0] port_q  [0:NP-1];
    reg  [SW-1:0] stage_q [0:NP-1];
    wire          dmx_rst;
    wire          lclk_edge;
    wire          lclk_rise;
    wire          capture;
    wire          awake;
    wire          simul;
    wire          ratio4;
    wire          normal;
    wire          hold;
    wire [1:0]    last_idx;
    wire [SW-1:0] cap_data;
    wire          fifo_in_valid;
    wire          fifo_in_ready;
    wire          fifo_out_valid;
    wire          fifo_out_ready;
    wire [SW-1:0] fifo_out_data;
    wire [`SDM_FIFO_AW:0] fifo_count;
    wire          pop;
    wire          word_done;
    wire          edge_both;
    wire          full_rate;
    wire          fifo_full;
    wire          fifo_empty;
    wire          pattern_step;

    // Two-stage synchronisers for every link pin
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            lclk_s1_q <= 1'b0;
            lclk_s2_q <= 1'b0;
            lclk_s3_q <= 1'b0;
            ldat_s1_q <= {SW{1'b0}};
            ldat_s2_q <= {SW{1'b0}};
            drst_s1_q <= 1'b0;
            drst_s2_q <= 1'b0;
        end else begin
            lclk_s1_q <= LINK_CLK;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
            ldat_s1_q <= LINK_DATA;
            ldat_s2_q <= ldat_s1_q;
            drst_s1_q <= DEMUX_RESET_IN;
            drst_s2_q <= drst_s1_q;
        end
    end

    assign dmx_rst   = drst_s2_q;
    assign lclk_edge = lclk_s2_q ^ lclk_s3_q;
    assign lclk_rise = lclk_s2_q & ~lclk_s3_q;

    // Settings: latched ones from act_q, live ones from ctrl_q
    assign awake    = act_q[`SDM_AWAKE_BIT];
    assign simul    = act_q[`SDM_SIMUL_BIT];
    assign ratio4   = ctrl_q[`SDM_RATIO_BIT];
    assign normal   = ctrl_q[`SDM_NORMAL_BIT];
    assign hold     = ctrl_q[`SDM_HOLD_BIT];
    assign last_idx = ratio4 ? 2'h3 : 2'h1;
    assign edge_both = act_q[`SDM_EDGE_BIT];
    assign full_rate = act_q[`SDM_RATE_BIT];

    // Both edges or rising edge only
    assign capture  = edge_both ? lclk_edge : lclk_rise;

    // Test pattern in place of converter data
    assign cap_data = normal ? ldat_s2_q : pattern_q;
    assign pattern_step = capture & ~normal & awake;

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pattern_q <= {SW{1'b0}};
        end else if (dmx_rst) begin
            pattern_q <= {SW{1'b0}};
        end else if (pattern_step) begin
            pattern_q <= pattern_q + {{(SW-1){1'b0}}, 1'b1};
        end
    end

    // Sleep drops capture, demux reset flushes
    assign fifo_in_valid  = capture & awake & ~dmx_rst;
    assign fifo_out_ready = ~hold & awake & ~dmx_rst;

    sdm_fifo #(
        .WIDTH (SW),
        .DEPTH (`SDM_FIFO_DEPTH),
        .AW    (`SDM_FIFO_AW)
    ) u_fifo (
        .clk       (CLK),
        .rst_b     (RST_B),
        .flush     (dmx_rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (cap_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .count     (fifo_count)
    );

    assign pop       = fifo_out_valid & fifo_out_ready;
    assign word_done = pop & (idx_q == last_idx);
    assign fifo_full  = ~fifo_in_ready;
    assign fifo_empty = ~fifo_out_valid;

    // Port index: starts at A, wraps after the last port
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            idx_q <= 2'h0;
        end else if (dmx_rst) begin
            idx_q <= 2'h0;
        end else if (pop) begin
            if (idx_q >= last_idx) begin
                idx_q <= 2'h0;
            end else begin
                idx_q <= idx_q + 2'h1;
            end
        end
    end

    // Per-port staging and output registers
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_port
            wire mine;
            wire in_word;
            wire load_word;
            assign mine      = pop & ({30'h0, idx_q} == g);
            assign in_word   = ({30'h0, last_idx} >= g);
            assign load_word = word_done & in_word;
            always @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    stage_q[g] <= {SW{1'b0}};
                    port_q[g]  <= {SW{1'b0}};
                end else if (dmx_rst) begin
                    stage_q[g] <= {SW{1'b0}};
                end else if (!simul) begin
                    if (mine) begin
                        port_q[g] <= fifo_out_data;
                    end
                end else begin
                    if (mine) begin
                        stage_q[g] <= fifo_out_data;
                    end
                    if (load_word) begin
                        port_q[g] <= mine ? fifo_out_data : stage_q[g];
                    end
                end
            end
        end
    endgenerate

    // Output clock: pulse per word at full rate, toggle per word at half rate
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            oclk_q <= 1'b0;
        end else if (dmx_rst) begin
            oclk_q <= 1'b0;
        end else if (full_rate) begin
            if (word_done) begin
                oclk_q <= 1'b1;
            end else if (pop) begin
                oclk_q <= 1'b0;
            end
        end else if (word_done) begin
            oclk_q <= ~oclk_q;
        end
    end

    // Settings take effect at power-up and at each demux reset
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            act_q <= `SDM_ACTIVE_RST;
        end else if (dmx_rst) begin
            act_q <= ctrl_q[3:0];
        end
    end

    // Overflow when the FIFO refuses a captured sample
    always @* begin
        ovf_d = ovf_q;
        if (ovf_clr) begin
            ovf_d = 1'b0;
        end
        if (ovf_set) begin
            ovf_d = 1'b1;
        end
    end

    // AHB-Lite address phase
    assign addr_ok = HSEL & HREADY & HTRANS[1];
    assign rd_take = addr_ok & ~HWRITE;
    assign wr_take = addr_ok & HWRITE;

    // Data-phase write strobes
    assign wr_ctrl   = wr_pend_q & (wr_addr_q == `SDM_CTRL_OFS);
    assign wr_status = wr_pend_q & (wr_addr_q == `SDM_STATUS_OFS);
    assign ovf_clr   = wr_status & HWDATA[`SDM_ST_OVF_BIT];
    assign ovf_set   = fifo_in_valid & fifo_full;

    always @* begin
        rd_val = 32'h0000_0000;
        if (HADDR[11:0] == `SDM_CTRL_OFS) begin
            rd_val[8:0] = ctrl_q;
        end else if (HADDR[11:0] == `SDM_STATUS_OFS) begin
            rd_val[`SDM_ST_IDX_MSB:`SDM_ST_IDX_LSB] = idx_q;
            rd_val[`SDM_ST_OVF_BIT]   = ovf_q;
            rd_val[`SDM_ST_EMPTY_BIT] = fifo_empty;
            rd_val[`SDM_ST_FULL_BIT]  = fifo_full;
            rd_val[`SDM_ST_CNT_MSB:`SDM_ST_CNT_LSB] = fifo_count;
        end else if (HADDR[11:0] == `SDM_ACTIVE_OFS) begin
            rd_val[3:0] = act_q;
        end
    end

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 12'h000;
            hrdata_q    <= 32'h0000_0000;
        end else if (HREADY) begin
            wr_pend_q <= wr_take;
            wr_addr_q <= {HADDR[11:2], 2'b00};
            if (rd_take) begin
                hrdata_q <= rd_val;
            end
        end
    end

    // Zero wait states, always OKAY
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            hreadyout_q <= 1'b0;
            hresp_q     <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    // AHB-Lite data phase writes
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= `SDM_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= HWDATA[8:0];
        end
    end

    // Sticky overflow, set wins over clear
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_d;
        end
    end

    assign HRDATA    = hrdata_q;
    assign HREADYOUT = hreadyout_q;
    assign HRESP     = hresp_q;
    assign PORT_A    = port_q[0];
    assign PORT_B    = port_q[1];
    assign PORT_C    = port_q[2];
    assign PORT_D    = port_q[3];
    assign OUT_CLK   = oclk_q;
endmodule // sdm_top
